//--- dqf_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module dqf_decoder
	import dqf_pkg::*;
#(
	parameter longint PAGE_CYCLES = PAGE_WRITE_CYCLES,
	parameter longint PHYS_CYCLES = PHYS_ERASE_CYCLES,
	parameter longint LBIG_CYCLES = LOGICAL_BIG_CYCLES,
	parameter longint LSMALL_CYCLES = LOGICAL_SMALL_CYCLES,
	parameter longint WHOLE_CYCLES = WHOLE_ERASE_CYCLES,
	parameter int PPAUSE_CYCLES = PROGRAM_PAUSE_CYCLES,
	parameter int EPAUSE_CYCLES = ERASE_PAUSE_CYCLES
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// Serial link from host, mode 0
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_si,
	// Self-timed job setup
	input wire dqf_pkg::dqf_len_t i_job_len,
	// Decoded instruction stream
	output logic o_cmd_valid,
	input wire logic i_cmd_ready,
	output logic [7:0] o_cmd_opcode,
	output dqf_pkg::dqf_op_t o_cmd_op,
	output logic [7:0] o_cmd_max_mhz,
	// Status
	output logic o_write_in_progress_flag,
	output logic o_write_enable_latch,
	output logic o_erase_fail,
	output logic o_program_fail,
	output logic o_program_paused,
	output logic o_erase_paused,
	output logic o_overflow
);
	import dqf_pkg::*;

	typedef enum {ST_IDLE, ST_PROG, ST_ERASE, ST_PROG_PAUSING, ST_ERASE_PAUSING} dqf_state_t;

	// Pin synchronisers
	logic [1:0] sck_sync;
	logic [1:0] cs_sync;
	logic [1:0] si_sync;
	logic sck_prev;
	logic cs_prev;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sck_sync <= 2'b00;
			cs_sync <= 2'b11;
			si_sync <= 2'b00;
			sck_prev <= 1'b0;
			cs_prev <= 1'b1;
		end else begin
			sck_sync <= {sck_sync[0], i_sck};
			cs_sync <= {cs_sync[0], i_cs_n};
			si_sync <= {si_sync[0], i_si};
			sck_prev <= sck_sync[1];
			cs_prev <= cs_sync[1];
		end
	end
	wire sck_rise = sck_sync[1] && !sck_prev;
	wire selected = !cs_sync[1];
	wire cs_fall = cs_prev && !cs_sync[1];
	wire cs_rise = !cs_prev && cs_sync[1];

	// Shift in only the first byte of each frame
	logic [7:0] shift;
	logic [3:0] bits;
	logic [7:0] opcode;
	logic have_op;
	wire byte_done = selected && sck_rise && bits == 4'd7;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			shift <= 8'h00;
			bits <= 4'd0;
			opcode <= 8'h00;
			have_op <= 1'b0;
		end else if (cs_fall) begin
			bits <= 4'd0;
			have_op <= 1'b0;
		end else if (selected && sck_rise && bits < 4'd8) begin
			shift <= {shift[6:0], si_sync[1]};
			bits <= bits + 4'd1;
			if (byte_done) begin
				opcode <= {shift[6:0], si_sync[1]};
				have_op <= 1'b1;
			end
		end
	end
	wire [7:0] new_op = {shift[6:0], si_sync[1]};

	// Opcode to operation class
	dqf_op_t dec_op;
	always_comb begin
		unique case (new_op)
			OP_STATUS_CONFIG_WRITE: dec_op = DQF_OP_REG_WRITE;
			OP_NORMAL_READ, OP_WIDE_NORMAL_READ: dec_op = DQF_OP_READ;
			OP_ACCEL_READ, OP_WIDE_ACCEL_READ: dec_op = DQF_OP_ACCEL_READ;
			OP_FOUR_OUT_READ, OP_WIDE_FOUR_OUT_READ: dec_op = DQF_OP_FOUR_READ;
			OP_PAGE_WRITE, OP_WIDE_PAGE_WRITE: dec_op = DQF_OP_PAGE_WRITE;
			OP_FOUR_PAGE_WRITE, OP_FOUR_PAGE_WRITE_ALT, OP_WIDE_FOUR_PAGE_WRITE: dec_op = DQF_OP_FOUR_PAGE_WRITE;
			OP_SMALL_ERASE, OP_WIDE_SMALL_ERASE: dec_op = DQF_OP_SMALL_ERASE;
			OP_CLEAR_STATUS: dec_op = DQF_OP_CLEAR_STATUS;
			OP_TRAIN_READ: dec_op = DQF_OP_TRAIN_READ;
			OP_PERSIST_TRAIN_WRITE: dec_op = DQF_OP_PERSIST_TRAIN;
			OP_VOLATILE_TRAIN_WRITE: dec_op = DQF_OP_VOLATILE_TRAIN;
			OP_MAKER_SIG_READ: dec_op = DQF_OP_MAKER_SIG;
			OP_IDENT_READ: dec_op = DQF_OP_IDENT;
			OP_WRITE_ENABLE: dec_op = DQF_OP_WRITE_ENABLE;
			OP_WRITE_DISABLE: dec_op = DQF_OP_WRITE_DISABLE;
			OP_PROGRAM_PAUSE: dec_op = DQF_OP_PROG_PAUSE;
			OP_PROGRAM_CONTINUE: dec_op = DQF_OP_PROG_CONTINUE;
			OP_ERASE_PAUSE: dec_op = DQF_OP_ERASE_PAUSE;
			OP_ERASE_CONTINUE: dec_op = DQF_OP_ERASE_CONTINUE;
			OP_WHOLE_ERASE: dec_op = DQF_OP_WHOLE_ERASE;
			OP_ONE_TIME_WRITE, OP_PROT_MODE_WRITE, OP_SECRET_KEY_WRITE, OP_BOOT_CONFIG_WRITE,
			OP_PROTECT_WRITE: dec_op = DQF_OP_REG_PROGRAM;
			OP_PROTECT_ERASE: dec_op = DQF_OP_PROT_ERASE;
			OP_SW_RESET: dec_op = DQF_OP_SW_RESET;
			default: dec_op = DQF_OP_NONE; // Reserved A3h lands here too
		endcase
	end

	// Highest clock for the class
	wire [7:0] dec_mhz = (dec_op == DQF_OP_READ) ? 8'(MAX_MHZ_NORMAL_READ) :
		(dec_op == DQF_OP_FOUR_READ) ? 8'(MAX_MHZ_FOUR_OUT_READ) :
		(dec_op == DQF_OP_FOUR_PAGE_WRITE) ? 8'(MAX_MHZ_FOUR_PAGE_WRITE) :
		8'(MAX_MHZ_DEFAULT);

	// Report stream; unknown opcodes never enter it
	logic buf_ready;
	logic overflow;
	logic [20:0] head;
	wire report = byte_done && dec_op != DQF_OP_NONE;
	dqf_skid #(
		.WIDTH(21)
	) u_skid (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_valid(report),
		.o_ready(buf_ready),
		.i_data({new_op, dec_op, dec_mhz}),
		.o_valid(o_cmd_valid),
		.i_ready(i_cmd_ready),
		.o_data(head)
	);

	// Head entry split back into its fields; the class needs a cast to the enum
	assign o_cmd_opcode = head[20:13];
	assign o_cmd_op = dqf_op_t'(head[12:8]);
	assign o_cmd_max_mhz = head[7:0];

	// A report that finds the buffer full is lost and sets the sticky overflow flag
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) overflow <= 1'b0;
		else if (report && !buf_ready) overflow <= 1'b1;
	end
	assign o_overflow = overflow;

	// Frame end launches the decoded action, as the device acts on chip select rising
	dqf_op_t cur_op;
	always_comb begin
		cur_op = DQF_OP_NONE;
		unique case (opcode)
			OP_WRITE_ENABLE: cur_op = DQF_OP_WRITE_ENABLE;
			OP_WRITE_DISABLE: cur_op = DQF_OP_WRITE_DISABLE;
			OP_CLEAR_STATUS: cur_op = DQF_OP_CLEAR_STATUS;
			OP_PROGRAM_PAUSE: cur_op = DQF_OP_PROG_PAUSE;
			OP_PROGRAM_CONTINUE: cur_op = DQF_OP_PROG_CONTINUE;
			OP_ERASE_PAUSE: cur_op = DQF_OP_ERASE_PAUSE;
			OP_ERASE_CONTINUE: cur_op = DQF_OP_ERASE_CONTINUE;
			OP_SW_RESET: cur_op = DQF_OP_SW_RESET;
			OP_STATUS_CONFIG_WRITE, OP_PAGE_WRITE, OP_WIDE_PAGE_WRITE, OP_FOUR_PAGE_WRITE,
			OP_FOUR_PAGE_WRITE_ALT, OP_WIDE_FOUR_PAGE_WRITE, OP_PERSIST_TRAIN_WRITE,
			OP_ONE_TIME_WRITE, OP_PROT_MODE_WRITE, OP_SECRET_KEY_WRITE, OP_BOOT_CONFIG_WRITE,
			OP_PROTECT_WRITE, OP_VOLATILE_TRAIN_WRITE: cur_op = DQF_OP_PAGE_WRITE;
			OP_SMALL_ERASE, OP_WIDE_SMALL_ERASE, OP_WHOLE_ERASE, OP_PROTECT_ERASE: cur_op = DQF_OP_SMALL_ERASE;
			default: cur_op = DQF_OP_NONE;
		endcase
	end
	wire act = cs_rise && have_op;
	wire act_program = act && cur_op == DQF_OP_PAGE_WRITE && opcode != OP_VOLATILE_TRAIN_WRITE;
	wire act_vol = act && opcode == OP_VOLATILE_TRAIN_WRITE;
	wire act_erase = act && cur_op == DQF_OP_SMALL_ERASE;

	// Self-timed sequencer
	dqf_state_t state;
	dqf_state_t next_state;
	logic [37:0] timer;
	logic [37:0] next_timer;
	logic write_enable_latch;
	logic erase_fail;
	logic program_fail;
	logic prog_paused;
	logic erase_paused;
	wire idle = state == ST_IDLE;
	wire start_ok = idle && write_enable_latch && !prog_paused && !erase_paused;
	wire timer_done = timer == 38'd1;

	// Duration of the erase the host set up
	wire [37:0] erase_len = (i_job_len == DQF_LEN_LOGICAL_BIG) ? 38'(LBIG_CYCLES) :
		(i_job_len == DQF_LEN_LOGICAL_SMALL) ? 38'(LSMALL_CYCLES) :
		(i_job_len == DQF_LEN_WHOLE) ? 38'(WHOLE_CYCLES) :
		38'(PHYS_CYCLES);

	// Next state and timer
	always_comb begin
		next_state = state;
		next_timer = (timer > 38'd1) ? timer - 38'd1 : timer;
		unique case (state)
			ST_IDLE: begin
				next_timer = timer; // Paused jobs keep their remaining time
				if (act_program && start_ok) begin
					next_state = ST_PROG;
					next_timer = 38'(PAGE_CYCLES);
				end else if (act_erase && start_ok) begin
					next_state = ST_ERASE;
					next_timer = erase_len;
				end else if (act && cur_op == DQF_OP_PROG_CONTINUE && prog_paused) begin
					next_state = ST_PROG;
				end else if (act && cur_op == DQF_OP_ERASE_CONTINUE && erase_paused) begin
					next_state = ST_ERASE;
				end
			end
			ST_PROG: begin
				if (timer_done) next_state = ST_IDLE;
				else if (act && cur_op == DQF_OP_PROG_PAUSE) next_state = ST_PROG_PAUSING;
			end
			ST_ERASE: begin
				if (timer_done) next_state = ST_IDLE;
				else if (act && cur_op == DQF_OP_ERASE_PAUSE) next_state = ST_ERASE_PAUSING;
			end
			ST_PROG_PAUSING, ST_ERASE_PAUSING: begin
				next_timer = timer;
			end
		endcase
		if (act && cur_op == DQF_OP_SW_RESET) begin
			next_state = ST_IDLE;
		end
	end

	// Pause latency counter, kept apart so the job timer is preserved
	logic [10:0] pause_cnt;
	wire pause_done = pause_cnt == 11'd1;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pause_cnt <= 11'd0;
		end else if (state == ST_PROG && next_state == ST_PROG_PAUSING) begin
			pause_cnt <= 11'(PPAUSE_CYCLES);
		end else if (state == ST_ERASE && next_state == ST_ERASE_PAUSING) begin
			pause_cnt <= 11'(EPAUSE_CYCLES);
		end else if (pause_cnt > 11'd1) begin
			pause_cnt <= pause_cnt - 11'd1;
		end
	end

	// State register; pausing ends at the latency bound
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= ST_IDLE;
			timer <= 38'd0;
		end else if ((state == ST_PROG_PAUSING || state == ST_ERASE_PAUSING) && pause_done) begin
			state <= ST_IDLE;
			timer <= timer;
		end else begin
			state <= next_state;
			timer <= next_timer;
		end
	end

	// Pause bookkeeping
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prog_paused <= 1'b0;
			erase_paused <= 1'b0;
		end else if (act && cur_op == DQF_OP_SW_RESET) begin
			prog_paused <= 1'b0;
			erase_paused <= 1'b0;
		end else begin
			if (state == ST_PROG_PAUSING && pause_done) prog_paused <= 1'b1;
			else if (idle && next_state == ST_PROG) prog_paused <= 1'b0;
			if (state == ST_ERASE_PAUSING && pause_done) erase_paused <= 1'b1;
			else if (idle && next_state == ST_ERASE) erase_paused <= 1'b0;
		end
	end

	// Write enable latch: set by enable while idle, cleared on accepted write start, volatile training write, disable or software reset
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			write_enable_latch <= RST_WEL;
		end else if (act && cur_op == DQF_OP_WRITE_ENABLE && idle) begin
			write_enable_latch <= 1'b1;
		end else if (act && (cur_op == DQF_OP_WRITE_DISABLE || cur_op == DQF_OP_SW_RESET)) begin
			write_enable_latch <= 1'b0;
		end else if ((act_program || act_erase) && start_ok) begin
			write_enable_latch <= 1'b0;
		end else if (act_vol && write_enable_latch && idle) begin
			write_enable_latch <= 1'b0;
		end
	end

	// Failure flags: no failure source here, only the clear path
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			erase_fail <= RST_FAIL;
			program_fail <= RST_FAIL;
		end else if (act && (cur_op == DQF_OP_CLEAR_STATUS || cur_op == DQF_OP_SW_RESET)) begin
			erase_fail <= 1'b0;
			program_fail <= 1'b0;
		end
	end

	// Busy flag follows the sequencer
	assign o_write_in_progress_flag = !idle;
	assign o_write_enable_latch = write_enable_latch;
	assign o_erase_fail = erase_fail;
	assign o_program_fail = program_fail;
	assign o_program_paused = prog_paused;
	assign o_erase_paused = erase_paused;
endmodule
`default_nettype wire

//--- dqf_pkg.sv
package dqf_pkg;
	// Instruction codes
	localparam logic [7:0] OP_STATUS_CONFIG_WRITE = 8'h01;
	localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OP_NORMAL_READ = 8'h03;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_ACCEL_READ = 8'h0B;
	localparam logic [7:0] OP_WIDE_ACCEL_READ = 8'h0C;
	localparam logic [7:0] OP_WIDE_PAGE_WRITE = 8'h12;
	localparam logic [7:0] OP_WIDE_NORMAL_READ = 8'h13;
	localparam logic [7:0] OP_BOOT_CONFIG_WRITE = 8'h15;
	localparam logic [7:0] OP_SMALL_ERASE = 8'h20;
	localparam logic [7:0] OP_WIDE_SMALL_ERASE = 8'h21;
	localparam logic [7:0] OP_PROT_MODE_WRITE = 8'h2F;
	localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
	localparam logic [7:0] OP_FOUR_PAGE_WRITE = 8'h32;
	localparam logic [7:0] OP_WIDE_FOUR_PAGE_WRITE = 8'h34;
	localparam logic [7:0] OP_FOUR_PAGE_WRITE_ALT = 8'h38;
	localparam logic [7:0] OP_TRAIN_READ = 8'h41;
	localparam logic [7:0] OP_ONE_TIME_WRITE = 8'h42;
	localparam logic [7:0] OP_PERSIST_TRAIN_WRITE = 8'h43;
	localparam logic [7:0] OP_VOLATILE_TRAIN_WRITE = 8'h4A;
	localparam logic [7:0] OP_WHOLE_ERASE = 8'h60;
	localparam logic [7:0] OP_FOUR_OUT_READ = 8'h6B;
	localparam logic [7:0] OP_WIDE_FOUR_OUT_READ = 8'h6C;
	localparam logic [7:0] OP_ERASE_PAUSE = 8'h75;
	localparam logic [7:0] OP_ERASE_CONTINUE = 8'h7A;
	localparam logic [7:0] OP_PROGRAM_PAUSE = 8'h85;
	localparam logic [7:0] OP_PROGRAM_CONTINUE = 8'h8A;
	localparam logic [7:0] OP_MAKER_SIG_READ = 8'h90;
	localparam logic [7:0] OP_IDENT_READ = 8'h9F;
	localparam logic [7:0] OP_PERF_RESERVED = 8'hA3;
	localparam logic [7:0] OP_PROTECT_WRITE = 8'hE3;
	localparam logic [7:0] OP_PROTECT_ERASE = 8'hE4;
	localparam logic [7:0] OP_SECRET_KEY_WRITE = 8'hE8;
	localparam logic [7:0] OP_SW_RESET = 8'hF0;

	// Highest serial clock per class, MHz
	localparam int MAX_MHZ_DEFAULT = 133;
	localparam int MAX_MHZ_NORMAL_READ = 50;
	localparam int MAX_MHZ_FOUR_OUT_READ = 104;
	localparam int MAX_MHZ_FOUR_PAGE_WRITE = 80;

	// Operation classes on the decode output
	typedef enum logic [4:0] {
		DQF_OP_NONE, DQF_OP_REG_WRITE, DQF_OP_READ, DQF_OP_ACCEL_READ, DQF_OP_FOUR_READ,
		DQF_OP_PAGE_WRITE, DQF_OP_FOUR_PAGE_WRITE, DQF_OP_SMALL_ERASE, DQF_OP_CLEAR_STATUS,
		DQF_OP_TRAIN_READ, DQF_OP_PERSIST_TRAIN, DQF_OP_VOLATILE_TRAIN, DQF_OP_MAKER_SIG,
		DQF_OP_IDENT, DQF_OP_WRITE_ENABLE, DQF_OP_WRITE_DISABLE, DQF_OP_PROG_PAUSE,
		DQF_OP_PROG_CONTINUE, DQF_OP_ERASE_PAUSE, DQF_OP_ERASE_CONTINUE, DQF_OP_WHOLE_ERASE,
		DQF_OP_REG_PROGRAM, DQF_OP_PROT_ERASE, DQF_OP_SW_RESET
	} dqf_op_t;

	// Self-timed job lengths chosen by the host side
	typedef enum logic [2:0] {
		DQF_LEN_PAGE, DQF_LEN_PHYS_SECTOR, DQF_LEN_LOGICAL_BIG, DQF_LEN_LOGICAL_SMALL, DQF_LEN_WHOLE
	} dqf_len_t;

	// Clock and worst-case times
	localparam int CORE_CLK_KHZ = 25000;
	localparam int PROGRAM_PAUSE_LATENCY_US = 40;
	localparam int ERASE_PAUSE_LATENCY_US = 45;
	localparam int PAGE_WRITE_MAX_US = 750;
	localparam int PHYS_ERASE_MAX_MS = 650;
	localparam int LOGICAL_BIG_ERASE_MAX_MS = 2600;
	localparam int LOGICAL_SMALL_ERASE_MAX_MS = 10400;
	localparam int WHOLE_ERASE_MAX_S = 165;
	localparam int PROGRAM_PAUSE_CYCLES = PROGRAM_PAUSE_LATENCY_US * CORE_CLK_KHZ / 1000;
	localparam int ERASE_PAUSE_CYCLES = ERASE_PAUSE_LATENCY_US * CORE_CLK_KHZ / 1000;
	localparam longint PAGE_WRITE_CYCLES = longint'(PAGE_WRITE_MAX_US) * CORE_CLK_KHZ / 1000;
	localparam longint PHYS_ERASE_CYCLES = longint'(PHYS_ERASE_MAX_MS) * CORE_CLK_KHZ;
	localparam longint LOGICAL_BIG_CYCLES = longint'(LOGICAL_BIG_ERASE_MAX_MS) * CORE_CLK_KHZ;
	localparam longint LOGICAL_SMALL_CYCLES = longint'(LOGICAL_SMALL_ERASE_MAX_MS) * CORE_CLK_KHZ;
	localparam longint WHOLE_ERASE_CYCLES = longint'(WHOLE_ERASE_MAX_S) * CORE_CLK_KHZ * 1000;

	// Status flag reset values
	localparam logic RST_BUSY = 1'b0;
	localparam logic RST_WEL = 1'b0;
	localparam logic RST_FAIL = 1'b0;
endpackage

//--- dqf_skid.sv
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer; upstream ready depends only on fill level
module dqf_skid #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// Fill side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	// Drain side
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	logic [WIDTH-1:0] mem [2];
	logic rd_ptr;
	logic wr_ptr;
	logic [1:0] count;
	wire push = i_valid && o_ready;
	wire pop = o_valid && i_ready;

	// Handshakes from level only, so no combinational path through
	assign o_ready = (count != 2'd2);
	assign o_valid = (count != 2'd0);
	assign o_data = mem[rd_ptr];

	// Pointers and level
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			count <= 2'd0;
		end else begin
			if (push) wr_ptr <= ~wr_ptr;
			if (pop) rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	// Storage
	always_ff @(posedge i_core_clk) begin
		if (push) mem[wr_ptr] <= i_data;
	end
endmodule
`default_nettype wire

//--- dqf_decoder_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dqf_decoder_chk
	import dqf_pkg::*;
#(
	parameter longint WHOLE_CYCLES = WHOLE_ERASE_CYCLES,
	parameter int PPAUSE_CYCLES = PROGRAM_PAUSE_CYCLES,
	parameter int EPAUSE_CYCLES = ERASE_PAUSE_CYCLES
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// Link
	input wire logic i_cs_n,
	// Stream and status
	input wire logic i_cmd_ready,
	input wire logic o_cmd_valid,
	input wire logic [7:0] o_cmd_opcode,
	input wire dqf_pkg::dqf_op_t o_cmd_op,
	input wire logic [7:0] o_cmd_max_mhz,
	input wire logic o_write_in_progress_flag,
	input wire logic o_write_enable_latch,
	input wire logic o_program_paused,
	input wire logic o_erase_paused,
	input wire logic o_overflow
);
	localparam int PP_LIM = PPAUSE_CYCLES + 4;
	localparam int EP_LIM = EPAUSE_CYCLES + 4;
	logic busy;
	longint busy_cnt;
	logic pp_arm;
	logic ep_arm;
	int pp_cnt;
	int ep_cnt;
	assign busy = o_write_in_progress_flag;
	default clocking @(posedge i_core_clk);
	endclocking
	default disable iff (!i_reset_n);
	// Busy run length; a pause ends the run, so resumes restart it
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy ? busy_cnt + 1 : 0;
		end
	end
	// Busy cycles since a pause frame closed; assumes the pause matches the job and the stream is drained
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pp_arm <= 1'b0;
			ep_arm <= 1'b0;
			pp_cnt <= 0;
			ep_cnt <= 0;
		end else begin
			pp_arm <= busy && (pp_arm || (o_cmd_valid && o_cmd_op == DQF_OP_PROG_PAUSE && !i_cs_n));
			ep_arm <= busy && (ep_arm || (o_cmd_valid && o_cmd_op == DQF_OP_ERASE_PAUSE && !i_cs_n));
			pp_cnt <= (busy && (pp_cnt != 0 || (pp_arm && i_cs_n))) ? pp_cnt + 1 : 0;
			ep_cnt <= (busy && (ep_cnt != 0 || (ep_arm && i_cs_n))) ? ep_cnt + 1 : 0;
		end
	end
	a_start_needs_wel: assert property (
		$rose(busy) && !$past(o_program_paused) && !$past(o_erase_paused) |-> $past(o_write_enable_latch))
		else $error("job started without write enable");
	a_report_holds: assert property (
		o_cmd_valid && !i_cmd_ready |=> o_cmd_valid && $stable(o_cmd_opcode) && $stable(o_cmd_op))
		else $error("stalled report changed");
	a_read_mhz: assert property (
		o_cmd_valid && o_cmd_op == DQF_OP_READ |-> o_cmd_max_mhz == 8'h32)
		else $error("normal read ceiling wrong");
	a_quad_read_mhz: assert property (
		o_cmd_valid && o_cmd_op == DQF_OP_FOUR_READ |-> o_cmd_max_mhz == 8'h68)
		else $error("four-lane read ceiling wrong");
	a_quad_write_mhz: assert property (
		o_cmd_valid && o_cmd_op == DQF_OP_FOUR_PAGE_WRITE |-> o_cmd_max_mhz == 8'h50)
		else $error("four-lane write ceiling wrong");
	a_accel_decode: assert property (
		o_cmd_valid && o_cmd_op == DQF_OP_ACCEL_READ |-> o_cmd_opcode inside {8'h0B, 8'h0C} && o_cmd_max_mhz == 8'h85)
		else $error("accelerated read decode wrong");
	a_reserved_silent: assert property (
		o_cmd_valid |-> o_cmd_opcode != 8'hA3 && o_cmd_op != DQF_OP_NONE)
		else $error("undefined opcode reported");
	a_prog_pause_lat: assert property (
		pp_cnt <= PP_LIM)
		else $error("program pause too slow");
	a_erase_pause_lat: assert property (
		ep_cnt <= EP_LIM)
		else $error("erase pause too slow");
	a_busy_bounded: assert property (
		busy_cnt <= WHOLE_CYCLES)
		else $error("busy run too long");
	// Main scenarios reached
	c_job: cover property ($rose(busy));
	c_ppause: cover property ($rose(o_program_paused));
	c_epause: cover property ($rose(o_erase_paused));
	c_overflow: cover property ($rose(o_overflow));
endmodule
bind dqf_decoder dqf_decoder_chk #(.WHOLE_CYCLES(WHOLE_CYCLES), .PPAUSE_CYCLES(PPAUSE_CYCLES),
	.EPAUSE_CYCLES(EPAUSE_CYCLES)) u_chk (
	.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n), .i_cmd_ready(i_cmd_ready),
	.o_cmd_valid(o_cmd_valid), .o_cmd_opcode(o_cmd_opcode), .o_cmd_op(o_cmd_op),
	.o_cmd_max_mhz(o_cmd_max_mhz), .o_write_in_progress_flag(o_write_in_progress_flag),
	.o_write_enable_latch(o_write_enable_latch), .o_program_paused(o_program_paused),
	.o_erase_paused(o_erase_paused), .o_overflow(o_overflow)
);
`default_nettype wire

//--- dqf_host.sv
`timescale 1ns/1ps
`default_nettype none
module dqf_host (
	// Serial link to the device
	output logic o_sck,
	output logic o_cs_n,
	output logic o_si
);
	localparam int HALF = 160;
	// Idle link: deselected, clock parked low
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b1;
	end
	// Mode 0 frame, MSB first; phase kept apart from the core clock
	task automatic send(input logic [7:0] b, input int nbits);
		#13;
		o_cs_n = 1'b0;
		for (int i = 7; i > 7 - nbits; i--) begin
			o_si = b[i];
			#HALF o_sck = 1'b1; // 3.125 MHz is under every ceiling
			#HALF o_sck = 1'b0;
		end
		#HALF o_cs_n = 1'b1;
		o_si = ~o_si; // Released line must not hold a stale bit
		#200;
	endtask
endmodule
`default_nettype wire

//--- dqf_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dqf_decoder_tb_top;
	import dqf_pkg::*;
	localparam int PAGE = 300;
	localparam int PHYS = 400;
	localparam int PPAUSE = 10;
	localparam int EPAUSE = 12;
	localparam logic [7:0] TBL [22] = '{8'h01, 8'h03, 8'h13, 8'h0B, 8'h0C, 8'h6B, 8'h6C, 8'h02, 8'h12, 8'h32,
		8'h38, 8'h34, 8'h20, 8'h21, 8'h30, 8'h41, 8'h43, 8'h4A, 8'h90, 8'h9F, 8'hA3, 8'h5A};
	logic i_core_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_cmd_ready = 1'b0;
	dqf_len_t i_job_len = DQF_LEN_PAGE;
	logic sck, cs_n, si, o_cmd_valid, busy, write_enable_latch, efail, pfail, ppaused, epaused, ovf;
	logic [7:0] o_cmd_opcode, o_cmd_max_mhz;
	dqf_op_t o_cmd_op;
	int num_errors = 0;
	int check_count = 0;
	int seed = 64849;
	int cycles = 0;
	always #20 i_core_clk = ~i_core_clk;
	dqf_host host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si));
	dqf_decoder #(.PAGE_CYCLES(PAGE), .PHYS_CYCLES(PHYS), .LBIG_CYCLES(450), .LSMALL_CYCLES(500),
		.WHOLE_CYCLES(550), .PPAUSE_CYCLES(PPAUSE), .EPAUSE_CYCLES(EPAUSE)) DUT (
		.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
		.i_job_len(i_job_len), .o_cmd_valid(o_cmd_valid), .i_cmd_ready(i_cmd_ready),
		.o_cmd_opcode(o_cmd_opcode), .o_cmd_op(o_cmd_op), .o_cmd_max_mhz(o_cmd_max_mhz),
		.o_write_in_progress_flag(busy), .o_write_enable_latch(write_enable_latch), .o_erase_fail(efail),
		.o_program_fail(pfail), .o_program_paused(ppaused), .o_erase_paused(epaused), .o_overflow(ovf));
	// Expected class per opcode
	function automatic dqf_op_t exp_op(input logic [7:0] b);
		case (b)
			8'h01: return DQF_OP_REG_WRITE;
			8'h03, 8'h13: return DQF_OP_READ;
			8'h0B, 8'h0C: return DQF_OP_ACCEL_READ;
			8'h6B, 8'h6C: return DQF_OP_FOUR_READ;
			8'h02, 8'h12: return DQF_OP_PAGE_WRITE;
			8'h32, 8'h38, 8'h34: return DQF_OP_FOUR_PAGE_WRITE;
			8'h20, 8'h21: return DQF_OP_SMALL_ERASE;
			8'h30: return DQF_OP_CLEAR_STATUS;
			8'h41: return DQF_OP_TRAIN_READ;
			8'h43: return DQF_OP_PERSIST_TRAIN;
			8'h4A: return DQF_OP_VOLATILE_TRAIN;
			8'h90: return DQF_OP_MAKER_SIG;
			8'h9F: return DQF_OP_IDENT;
			8'h60: return DQF_OP_WHOLE_ERASE;
			default: return DQF_OP_NONE;
		endcase
	endfunction
	// Expected clock ceiling, MHz
	function automatic logic [7:0] exp_mhz(input logic [7:0] b);
		case (exp_op(b))
			DQF_OP_READ: return 8'h32;
			DQF_OP_FOUR_READ: return 8'h68;
			DQF_OP_FOUR_PAGE_WRITE: return 8'h50;
			default: return 8'h85;
		endcase
	endfunction
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic summarize();
		if (num_errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic pop();
		@(posedge i_core_clk);
		i_cmd_ready <= 1'b1;
		@(posedge i_core_clk);
		i_cmd_ready <= 1'b0;
		#1;
	endtask
	// One frame, optional decode check, then the stream is drained
	task automatic frame(input logic [7:0] b, input bit look);
		dqf_op_t e;
		e = exp_op(b);
		host.send(b, 8);
		repeat (6) @(posedge i_core_clk);
		#1;
		if (look) begin
			chk("valid", e != DQF_OP_NONE, o_cmd_valid);
			if (e != DQF_OP_NONE) begin
				chk("opcode", b, o_cmd_opcode);
				chk("op", e, o_cmd_op);
				chk("mhz", exp_mhz(b), o_cmd_max_mhz);
			end
		end
		repeat (2) if (o_cmd_valid === 1'b1) pop();
	endtask
	task automatic busy_len(input int limit, output int cnt);
		cnt = 0;
		while (busy === 1'b1 && cnt < limit) begin
			@(posedge i_core_clk);
			#1;
			cnt++;
		end
	endtask
	// Enabled self-timed job, run length measured against its bound
	task automatic job(input logic [7:0] b, input dqf_len_t len, input int n);
		int cnt;
		@(posedge i_core_clk);
		i_job_len <= len;
		frame(8'h06, 1'b0);
		chk("wel_set", 1'b1, write_enable_latch);
		frame(b, 1'b0);
		chk("busy", 1'b1, busy);
		chk("wel_used", 1'b0, write_enable_latch);
		busy_len(n + 20, cnt);
		chk("busy_len", 1'b1, cnt <= n && cnt + 12 >= n);
	endtask
	// Job paused and continued twice; pause latency bounded
	task automatic paused_job(input logic [7:0] b, pz, ct, input bit er, input int lim, n);
		int cnt;
		frame(8'h06, 1'b0);
		frame(b, 1'b0);
		for (int k = 0; k < 2; k++) begin
			frame(pz, 1'b0);
			busy_len(lim + 20, cnt);
			chk("pause_lat", 1'b1, cnt <= lim);
			chk("paused", 1'b1, er ? epaused : ppaused);
			frame(ct, 1'b0);
			chk("resumed", 1'b1, busy);
			repeat (2) @(posedge i_core_clk); // gap before pausing again
		end
		busy_len(n, cnt);
		chk("done", 1'b0, busy);
	endtask
	// Hang guard
	always @(posedge i_core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		logic [7:0] b;
		repeat (3) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		#1;
		chk("rst_flags", 1'b0, busy | write_enable_latch | ovf | o_cmd_valid);
		for (int i = 0; i < 22; i++) begin
			frame(TBL[i], 1'b1);
			chk("no_start", 1'b0, busy);
		end
		for (int i = 0; i < 12; i++) begin
			b = 8'($random(seed));
			if (b inside {8'h04, 8'h06, 8'h15, 8'h2F, 8'h42, 8'h75, 8'h7A, 8'h85, 8'h8A, 8'hE3, 8'hE4, 8'hE8, 8'hF0})
				b = 8'hA3;
			frame(b, 1'b1);
		end
		host.send(8'h06, 5);
		repeat (6) @(posedge i_core_clk);
		#1;
		chk("short_frame", 1'b0, write_enable_latch | o_cmd_valid);
		job(8'h02, DQF_LEN_PAGE, PAGE);
		job(8'h43, DQF_LEN_PAGE, PAGE);
		job(8'h01, DQF_LEN_PAGE, PAGE);
		job(8'h34, DQF_LEN_PAGE, PAGE);
		job(8'h20, DQF_LEN_PHYS_SECTOR, PHYS);
		job(8'h21, DQF_LEN_LOGICAL_BIG, 450);
		job(8'h20, DQF_LEN_LOGICAL_SMALL, 500);
		job(8'h60, DQF_LEN_WHOLE, 550);
		frame(8'h06, 1'b0);
		frame(8'h4A, 1'b1);
		chk("volatile_write", 1'b0, write_enable_latch | busy);
		frame(8'h30, 1'b1);
		chk("fails_clear", 1'b0, efail | pfail);
		@(posedge i_core_clk);
		i_job_len <= DQF_LEN_PHYS_SECTOR;
		paused_job(8'h02, 8'h85, 8'h8A, 1'b0, PPAUSE, PAGE + 40);
		paused_job(8'h20, 8'h75, 8'h7A, 1'b1, EPAUSE, PHYS + 40);
		// Consumer stalls: two reports held, third lost
		host.send(8'h03, 8);
		host.send(8'h0B, 8);
		chk("no_ovf", 1'b0, ovf);
		host.send(8'h6B, 8);
		repeat (6) @(posedge i_core_clk);
		#1;
		chk("ovf", 1'b1, ovf);
		chk("head0", 8'h03, o_cmd_opcode);
		pop();
		chk("head1", 8'h0B, o_cmd_opcode);
		pop();
		chk("empty", 1'b0, o_cmd_valid);
		// Disable, protect-bit erase and software reset
		frame(8'h06, 1'b0);
		frame(8'h04, 1'b0);
		chk("wel_off", 1'b0, write_enable_latch);
		frame(8'h06, 1'b0);
		frame(8'hE4, 1'b0);
		chk("prot_erase", 1'b1, busy);
		frame(8'hF0, 1'b0);
		chk("sw_reset", 1'b0, busy | write_enable_latch);
		// Reset in mid-job
		frame(8'h06, 1'b0);
		frame(8'h20, 1'b0);
		@(posedge i_core_clk);
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		#1;
		chk("reset_mid", 1'b0, busy | write_enable_latch | ovf | epaused);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		#1;
		chk("reset_idle", 1'b0, busy | write_enable_latch | o_cmd_valid);
		summarize();
	end
endmodule
`default_nettype wire
